// File: hdl/cas_defs.vh
// Constants for the arithmetic and processor status register bank
`ifndef CAS_DEFS_VH
`define CAS_DEFS_VH
`define CAS_ARITH_STATUS_ADDR   8'h04
`define CAS_PROC_STATUS_ADDR    8'h06
`define CAS_ARITH_RESET         8'hf0
`define CAS_PROC_RESET_POR      8'h3c
`define CAS_BIT_CARRY           0
`define CAS_BIT_DIGIT           1
`define CAS_BIT_ZERO            2
`define CAS_BIT_OVF             3
`define CAS_BIT_BROWNOUT        0
`define CAS_BIT_POWERON         1
`define CAS_BIT_POWERDOWN       2
`define CAS_BIT_TIMEOUT         3
`define CAS_BIT_IRQ_DIS         4
`define CAS_BIT_STACK_ROOM      5
`define CAS_MODE_DEC            2'h0
`define CAS_MODE_INC            2'h1
`define CAS_OP_NONE             3'h0
`define CAS_OP_ADD              3'h1
`define CAS_OP_SUB              3'h2
`define CAS_OP_RLC              3'h3
`define CAS_OP_RRC              3'h4
`define CAS_OP_LOGIC            3'h5
`define CAS_STACK_TOP           4'hf
`endif

// File: hdl/cas_status_regs.v
// Arithmetic and processor status registers of the core
`timescale 1ns/1ps
// Behaviour
// RULE1 - Two-bit mode per pointer: dec, inc, hold
// RULE2 - Overflow flag set on signed sign flip
// RULE3 - Digit carry from bit 3, borrow inverted
// RULE4 - Carry from bit 7, borrow inverted
// RULE5 - Subtract adds two's complement of operand
// RULE6 - Rotate through carry loads shifted-out bit
// RULE7 - Software cannot write timeout, powerdown, stack bits
// RULE8 - Stack room clears at Fh, sticky on wrap
// RULE9 - Global disable blocks all interrupts
// RULE10 - Timeout set by power-up/clear, cleared by watchdog
// RULE11 - Powerdown set power-up/clear, cleared by sleep
// RULE12 - Power-on clears poweron flag; software sets it
// RULE13 - Brown-out clears brownout flag; software sets it
// RULE14 - Brownout flag undefined when detection disabled
// RULE15 - Poweron flag tells power-on from other resets
// RULE16 - Top two processor status bits read zero
// RULE17 - Flag logic overrides writes to Z, DC, C
// RULE18 - Master clear keeps timeout and powerdown bits
// RULE19 - Any reset sets stack room, zeroes pointer
// RULE20 - Zero flag tracks zero result
`include "cas_defs.vh"
module cas_status_regs (
   input  wire       mclk,
   input  wire       rst_b,
   input  wire       por_event,
   input  wire       bor_event,
   input  wire       brownout_detect_enable,
   input  wire [2:0] alu_op,
   input  wire [7:0] alu_a,
   input  wire [7:0] alu_b,
   input  wire       wr_en,
   input  wire [7:0] wr_addr,
   input  wire [7:0] wr_data,
   input  wire [7:0] rd_addr,
   input  wire       watchdog_clear_instr,
   input  wire       watchdog_timeout,
   input  wire       sleep_instr,
   input  wire       stack_push,
   input  wire       stack_pop,
   input  wire       ptr0_access,
   input  wire       ptr1_access,
   input  wire [7:0] irq_pending,
   input  wire [7:0] irq_enable,
   output reg  [7:0] rd_data,
   output reg  [7:0] alu_result,
   output reg  [7:0] indirect_pointer_zero,
   output reg  [7:0] indirect_pointer_one,
   output wire [3:0] stack_ptr,
   output wire       irq_take,
   output wire [7:0] arith_status,
   output wire [7:0] processor_status
);

   // Flag and mode storage
   reg  [1:0] pointer1_mode_ff;
   reg  [1:0] pointer0_mode_ff;
   reg        signed_overflow_flag_ff;
   reg        zero_flag_ff;
   reg        digit_carry_flag_ff;
   reg        carry_flag_ff;
   reg        stack_room_flag_ff;
   reg        stack_wrapped_ff;
   reg        global_irq_disable_ff;
   reg        watchdog_timeout_flag_ff;
   reg        powerdown_flag_ff;
   reg        poweron_flag_ff;
   reg        brownout_reset_flag_ff;
   reg  [3:0] stack_ptr_ff;
   // Reset-cause and watchdog synchroniser stages
   reg        por_sync1_ff;
   reg        por_sync2_ff;
   reg        bor_sync1_ff;
   reg        bor_sync2_ff;
   reg        wdt_sync1_ff;
   reg        wdt_sync2_ff;
   reg        por_hold_ff;
   reg        bor_hold_ff;

   // Combinational flag helpers
   reg        nxt_c;
   reg        nxt_dc;
   reg        nxt_ov;
   reg        flags_hit;
   reg  [8:0] sum9;
   reg  [4:0] sum5;
   reg  [7:0] opnd_b;
   wire       wr_arith;
   wire       wr_proc;
   wire [3:0] nxt_sp;

   // Pointer post-access step by mode code
   function [7:0] cas_step;
      input [7:0] ptr;
      input [1:0] mode;
      begin
         case (mode)
            `CAS_MODE_DEC: cas_step = ptr - 8'h01;
            `CAS_MODE_INC: cas_step = ptr + 8'h01;
            default:       cas_step = ptr;
         endcase
      end
   endfunction

   // Add and subtract share the carry-chain flag path
   function cas_is_arith;
      input [2:0] op;
      begin
         cas_is_arith = (op == `CAS_OP_ADD) || (op == `CAS_OP_SUB);
      end
   endfunction

   // Ops that drive the carry bit; logic and idle leave it to software
   function cas_moves_carry;
      input [2:0] op;
      begin
         case (op)
            `CAS_OP_ADD, `CAS_OP_SUB, `CAS_OP_RLC, `CAS_OP_RRC: cas_moves_carry = 1'b1;
            default:                                         cas_moves_carry = 1'b0;
         endcase
      end
   endfunction

   assign wr_arith = wr_en && (wr_addr == `CAS_ARITH_STATUS_ADDR);
   assign wr_proc  = wr_en && (wr_addr == `CAS_PROC_STATUS_ADDR);
   assign stack_ptr = stack_ptr_ff;

   assign arith_status = {pointer1_mode_ff, pointer0_mode_ff, signed_overflow_flag_ff,
                          zero_flag_ff, digit_carry_flag_ff, carry_flag_ff};
   assign processor_status = {2'h0, stack_room_flag_ff, global_irq_disable_ff, // [RULE16]
                              watchdog_timeout_flag_ff, powerdown_flag_ff,
                              poweron_flag_ff, brownout_reset_flag_ff};

   // Interrupt gate: global disable wins over every source
   assign irq_take = ~global_irq_disable_ff && |(irq_pending & irq_enable); // [RULE9]

   // ALU flag generation; subtract is an add of the negated operand
   always @* begin
      opnd_b    = (alu_op == `CAS_OP_SUB) ? (~alu_b + 8'h01) : alu_b; // [RULE5]
      sum9      = {1'b0, alu_a} + {1'b0, opnd_b};
      sum5      = {1'b0, alu_a[3:0]} + {1'b0, opnd_b[3:0]};
      nxt_c     = carry_flag_ff;
      nxt_dc    = digit_carry_flag_ff;
      nxt_ov    = signed_overflow_flag_ff;
      flags_hit = 1'b0;
      alu_result = 8'h00;
      case (alu_op)
         `CAS_OP_ADD, `CAS_OP_SUB: begin
            alu_result = sum9[7:0];
            // Borrow is the inverse of carry; add of negation gives it, except a zero operand, which forces carry set
            nxt_c  = (alu_op == `CAS_OP_SUB && alu_b == 8'h00) ? 1'b1 : sum9[8]; // [RULE4]
            nxt_dc = (alu_op == `CAS_OP_SUB && alu_b[3:0] == 4'h0) ? 1'b1 : sum5[4]; // [RULE3]
            // Negated operand misleads the sign test at 80h, so use the raw one
            if (alu_op == `CAS_OP_SUB)
               nxt_ov = (alu_a[7] != alu_b[7]) && (sum9[7] != alu_a[7]); // [RULE2]
            else
               nxt_ov = (alu_a[7] == alu_b[7]) && (sum9[7] != alu_a[7]); // [RULE2]
            flags_hit = 1'b1;
         end
         `CAS_OP_RLC: begin
            // Old carry enters at the bottom
            alu_result = {alu_a[6:0], carry_flag_ff};
            nxt_c = alu_a[7]; // [RULE6]
         end
         `CAS_OP_RRC: begin
            // Old carry enters at the top
            alu_result = {carry_flag_ff, alu_a[7:1]};
            nxt_c = alu_a[0]; // [RULE6]
         end
         `CAS_OP_LOGIC: begin
            // Logic ops touch only the zero flag
            alu_result = alu_a & alu_b;
            flags_hit = 1'b1;
         end
         default: begin
            alu_result = alu_a;
         end
      endcase
   end

   // Pointer movement with the sticky wrap detector
   assign nxt_sp = stack_push ? stack_ptr_ff + 4'h1 :
                   stack_pop  ? stack_ptr_ff - 4'h1 : stack_ptr_ff;

   // Power and brown-out causes arrive while rst_b is low, so no reset here
   always @(posedge mclk) begin
      por_sync1_ff <= por_event;
      por_sync2_ff <= por_sync1_ff;
      bor_sync1_ff <= bor_event;
      bor_sync2_ff <= bor_sync1_ff;
   end

   // Watchdog time-out synchroniser
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wdt_sync1_ff <= 1'b0;
         wdt_sync2_ff <= 1'b0;
      end else begin
         wdt_sync1_ff <= watchdog_timeout;
         wdt_sync2_ff <= wdt_sync1_ff;
      end
   end

   // Arithmetic status register
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pointer1_mode_ff        <= 2'h3;
         pointer0_mode_ff        <= 2'h3;
         signed_overflow_flag_ff <= 1'b0;
         zero_flag_ff            <= 1'b0;
         digit_carry_flag_ff     <= 1'b0;
         carry_flag_ff           <= 1'b0;
      end else begin
         if (wr_arith) begin
            pointer1_mode_ff <= wr_data[7:6];
            pointer0_mode_ff <= wr_data[5:4];
         end
         // Flag logic takes precedence over a write of the same bits
         if (cas_is_arith(alu_op))
            signed_overflow_flag_ff <= nxt_ov; // [RULE2] [RULE17]
         else if (wr_arith)
            signed_overflow_flag_ff <= wr_data[`CAS_BIT_OVF];

         // Zero follows every add, subtract and logic result
         if (flags_hit)
            zero_flag_ff <= (alu_result == 8'h00); // [RULE20] [RULE17]
         else if (wr_arith)
            zero_flag_ff <= wr_data[`CAS_BIT_ZERO];

         // Digit carry only from the adder
         if (flags_hit)
            digit_carry_flag_ff <= nxt_dc; // [RULE3] [RULE17]
         else if (wr_arith)
            digit_carry_flag_ff <= wr_data[`CAS_BIT_DIGIT];

         // Rotates own the carry too, so their write is dropped as well
         if (cas_moves_carry(alu_op))
            carry_flag_ff <= nxt_c; // [RULE4] [RULE6] [RULE17]
         else if (wr_arith)
            carry_flag_ff <= wr_data[`CAS_BIT_CARRY];
      end
   end

   // Indirect pointers stepped after each access
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         indirect_pointer_zero <= 8'h00;
         indirect_pointer_one  <= 8'h00;
      end else begin
         // Each pointer follows its own mode field
         if (ptr0_access)
            indirect_pointer_zero <= cas_step(indirect_pointer_zero, pointer0_mode_ff); // [RULE1]
         if (ptr1_access)
            indirect_pointer_one <= cas_step(indirect_pointer_one, pointer1_mode_ff); // [RULE1]
      end
   end

   // Stack pointer and stack room flag; rst_b is any device reset
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stack_ptr_ff       <= 4'h0; // [RULE19]
         stack_room_flag_ff <= 1'b1; // [RULE19]
         stack_wrapped_ff   <= 1'b0;
      end else begin
         stack_ptr_ff <= nxt_sp;
         if (stack_push && stack_ptr_ff == `CAS_STACK_TOP)
            stack_wrapped_ff <= 1'b1; // [RULE8]
         // Software write ignored here; a wrap keeps the flag low until reset
         if (stack_wrapped_ff || (stack_push && stack_ptr_ff == `CAS_STACK_TOP))
            stack_room_flag_ff <= 1'b0; // [RULE8] [RULE7]
         // Reaching the top also clears it, so underflow shows too
         else if (nxt_sp == `CAS_STACK_TOP)
            stack_room_flag_ff <= 1'b0; // [RULE8]
         else
            stack_room_flag_ff <= 1'b1;
      end
   end

   // Processor status bits; master clear is rst_b and leaves timeout/powerdown alone
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         global_irq_disable_ff <= 1'b1;
      end else if (wr_proc) begin
         global_irq_disable_ff <= wr_data[`CAS_BIT_IRQ_DIS];
      end
   end

   // Timeout has no async reset so master clear keeps it; set wins
   always @(posedge mclk) begin
      if (por_sync2_ff || watchdog_clear_instr)
         watchdog_timeout_flag_ff <= 1'b1; // [RULE10] [RULE18]
      else if (wdt_sync2_ff)
         watchdog_timeout_flag_ff <= 1'b0; // [RULE10] [RULE7]
   end

   // Powerdown likewise survives master clear; set wins over sleep
   always @(posedge mclk) begin
      if (por_sync2_ff || watchdog_clear_instr)
         powerdown_flag_ff <= 1'b1; // [RULE11] [RULE18]
      else if (sleep_instr)
         powerdown_flag_ff <= 1'b0; // [RULE11]
   end

   // Delayed copy stretches the power-on clear by one cycle past por_sync2_ff; brown-out clear uses only its delayed copy
   always @(posedge mclk) begin
      por_hold_ff <= por_sync2_ff;
      bor_hold_ff <= bor_sync2_ff && brownout_detect_enable; // [RULE14]
   end

   // Power-on flag; hardware clear beats a software set in the same cycle
   always @(posedge mclk) begin
      if (por_sync2_ff || por_hold_ff)
         poweron_flag_ff <= 1'b0; // [RULE12] [RULE15]
      else if (wr_proc)
         poweron_flag_ff <= wr_data[`CAS_BIT_POWERON]; // [RULE12]
   end

   // Brown-out flag; a power-on counts as a brown-out so it starts at zero
   always @(posedge mclk) begin
      if (bor_hold_ff || por_sync2_ff)
         brownout_reset_flag_ff <= 1'b0; // [RULE13]
      else if (wr_proc)
         brownout_reset_flag_ff <= wr_data[`CAS_BIT_BROWNOUT]; // [RULE13]
   end

   // Register read port; unmapped addresses read zero
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 8'h00;
      end else begin
         case (rd_addr)
            `CAS_ARITH_STATUS_ADDR: rd_data <= arith_status;
            `CAS_PROC_STATUS_ADDR:  rd_data <= processor_status; // [RULE16]
            default:                rd_data <= 8'h00;
         endcase
      end
   end

endmodule

// File: verif/cas_status_sva.sv
// Concurrent checks on the status register bank ports
`timescale 1ns/1ps
module cas_status_sva (
   input wire       mclk,
   input wire       rst_b,
   input wire [2:0] alu_op,
   input wire [7:0] alu_a,
   input wire [7:0] alu_b,
   input wire [7:0] alu_result,
   input wire       wr_en,
   input wire [7:0] wr_addr,
   input wire [7:0] wr_data,
   input wire       sleep_instr,
   input wire [7:0] irq_pending,
   input wire [7:0] irq_enable,
   input wire       irq_take,
   input wire [3:0] stack_ptr,
   input wire [7:0] arith_status,
   input wire [7:0] processor_status
);
   // Subtract modelled as add of two's complement, so borrow is inverted carry
   wire [8:0] add_s = {1'b0, alu_a} + {1'b0, alu_b};
   wire [8:0] sub_s = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
   wire [4:0] add_n = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
   wire [4:0] sub_n = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01;
   wire       c_exp = (alu_op == 3'h1) ? add_s[8] : sub_s[8];
   wire       d_exp = (alu_op == 3'h1) ? add_n[4] : sub_n[4];
   wire       v_exp = (alu_a[7] == alu_b[7]) && (add_s[7] != alu_a[7]);
   wire       z_exp = (alu_result == 8'h00);
   wire       r_exp = (alu_op == 3'h3) ? alu_a[7] : alu_a[0];
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_carry_flag: assert property ((alu_op == 3'h1 || alu_op == 3'h2) |=>
      arith_status[0] == $past(c_exp)) else $error("carry flag wrong");
   a_digit_flag: assert property ((alu_op == 3'h1 || alu_op == 3'h2) |=>
      arith_status[1] == $past(d_exp)) else $error("digit carry flag wrong");
   a_ovf_flag: assert property (alu_op == 3'h1 |=> arith_status[3] == $past(v_exp))
      else $error("overflow flag wrong");
   a_zero_flag: assert property ((alu_op inside {3'h1, 3'h2, 3'h5}) |=>
      arith_status[2] == $past(z_exp)) else $error("zero flag wrong");
   a_rotate_carry: assert property ((alu_op == 3'h3 || alu_op == 3'h4) |=>
      arith_status[0] == $past(r_exp)) else $error("rotate carry wrong");
   a_irq_gate: assert property (irq_take ==
      (!processor_status[4] && |(irq_pending & irq_enable))) else $error("irq gate wrong");
   a_sleep_clears: assert property (sleep_instr |=> !processor_status[2])
      else $error("sleep left powerdown set");
   a_top_zero: assert property (processor_status[7:6] == 2'h0)
      else $error("top bits not zero");
   a_stack_full: assert property (stack_ptr == 4'hf |-> !processor_status[5])
      else $error("stack room at full");
   a_mode_write: assert property (wr_en && wr_addr == 8'h04 |=>
      arith_status[7:4] == $past(wr_data[7:4])) else $error("mode write lost");
   c_add_wrap: cover property (alu_op == 3'h1 && alu_a[7] && alu_b[7]);
   c_stack_full: cover property (stack_ptr == 4'hf);
   c_sleep: cover property (sleep_instr);
endmodule

// File: verif/cas_core_model.sv
// Reset source model: power-on and master-clear sequencing
`timescale 1ns/1ps
module cas_core_model (
   input  wire mclk,
   input  wire por_req,
   input  wire master_clear_pin_req,
   output wire rst_b,
   output wire por_event
);
   reg [2:0] cnt_ff = 3'h5; // Power-up starts inside a reset
   reg       pwr_ff = 1'b1;
   // Every reset cause holds the core five cycles
   always @(posedge mclk) begin
      if (por_req || master_clear_pin_req)
         cnt_ff <= 3'h5;
      else if (cnt_ff != 3'h0)
         cnt_ff <= cnt_ff - 3'h1;
   end
   // Cause drops on the release edge, after the synchroniser has seen it
   always @(posedge mclk) begin
      if (por_req)
         pwr_ff <= 1'b1;
      else if (cnt_ff == 3'h1)
         pwr_ff <= 1'b0;
   end
   assign rst_b = (cnt_ff == 3'h0);
   assign por_event = pwr_ff;
endmodule

// File: verif/cas_status_regs_tb_top.sv
// Self-checking bench for the status register bank
`timescale 1ns/1ps
module cas_status_regs_tb_top;
   reg         mclk = 1'b0;
   reg         por_req = 1'b0;
   reg         master_clear_pin_req = 1'b0;
   reg  [2:0]  alu_op = 3'h0;
   reg  [7:0]  alu_a = 8'h00, alu_b = 8'h00, wr_addr = 8'h00, wr_data = 8'h00;
   reg  [7:0]  rd_addr = 8'h00, pls = 8'h00, irq_pending = 8'h00, irq_enable = 8'h00;
   reg         wr_en = 1'b0;
   reg  [35:0] r;
   wire        rst_b, por_event, irq_take;
   wire [3:0]  stack_ptr;
   wire [7:0]  rd_data, alu_result, p0, p1, arith_status, processor_status;
   int         err_total = 0;
   int         samples_checked = 0;
   // Rows: op, a, b, result, flags OV Z DC C, flag mask
   reg  [35:0] rows [0:12] = '{36'h1_7f_01_80_a_f, 36'h1_ff_01_00_7_f, 36'h1_80_80_00_d_f,
      36'h2_05_05_00_7_f, 36'h2_10_01_0f_1_f, 36'h2_00_01_ff_0_f, 36'h2_80_01_7f_9_f,
      36'h3_81_00_00_1_1, 36'h3_7f_00_00_0_1, 36'h4_01_00_00_1_1, 36'h4_02_00_00_0_1,
      36'h5_f0_0f_00_4_4, 36'h5_ff_01_01_0_4};
   always #20 mclk = ~mclk;
   cas_core_model i_core (.mclk, .por_req, .master_clear_pin_req, .rst_b, .por_event);
   cas_status_regs i_dut (.mclk, .rst_b, .por_event, .bor_event(pls[7]),
      .brownout_detect_enable(1'b1), .alu_op, .alu_a, .alu_b, .wr_en, .wr_addr, .wr_data,
      .rd_addr, .watchdog_clear_instr(pls[1]), .watchdog_timeout(pls[2]),
      .sleep_instr(pls[0]), .stack_push(pls[3]), .stack_pop(pls[4]), .ptr0_access(pls[5]),
      .ptr1_access(pls[6]), .irq_pending, .irq_enable, .rd_data, .alu_result,
      .indirect_pointer_zero(p0), .indirect_pointer_one(p1), .stack_ptr, .irq_take,
      .arith_status, .processor_status);
   task chk(input [7:0] got, input [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge mclk) {wr_en, wr_addr, wr_data} <= {1'b1, a, d};
      @(posedge mclk) wr_en <= 1'b0;
      #1;
   endtask
   task hit(input int k);
      @(posedge mclk) pls <= 8'h01 << k;
      @(posedge mclk) pls <= 8'h00;
      #1;
   endtask
   // Pulse sources are synchronised, so allow settling
   task settle;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task rst(input p);
      @(posedge mclk) {por_req, master_clear_pin_req} <= {p, !p};
      @(posedge mclk) {por_req, master_clear_pin_req} <= 2'h0;
      #1 wait (rst_b === 1'b1);
      settle;
   endtask
   task end_of_test;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #40000;
      err_total++;
      end_of_test;
   end
   initial begin
      wait (rst_b === 1'b1);
      settle;
      chk(processor_status, 8'h3c);
      chk(arith_status, 8'hf0);
      // Table of arithmetic cases; rotate results depend on old carry
      for (int i = 0; i < 13; i++) begin
         r = rows[i];
         @(posedge mclk) {alu_op, alu_a, alu_b} <= r[34:16];
         #1 if (r[34:32] != 3'h3 && r[34:32] != 3'h4) chk(alu_result, r[15:8]);
         @(posedge mclk) alu_op <= 3'h0;
         #1 chk({4'h0, arith_status[3:0] & r[3:0]}, {4'h0, r[7:4]});
      end
      wr(8'h06, 8'hff);
      chk(processor_status, 8'h3f);
      wr(8'h06, 8'h03);
      chk(processor_status, 8'h2f);
      @(posedge mclk) {irq_pending, irq_enable} <= 16'h8180;
      #1 chk({7'h0, irq_take}, 8'h01);
      wr(8'h06, 8'h13);
      chk({7'h0, irq_take}, 8'h00);
      hit(0);
      chk(processor_status, 8'h3b);
      hit(1);
      chk(processor_status, 8'h3f);
      hit(2);
      settle;
      chk(processor_status, 8'h37);
      rst(1'b0);
      chk(processor_status, 8'h37);
      hit(7);
      settle;
      chk(processor_status, 8'h36);
      rst(1'b1);
      chk(processor_status, 8'h3c);
      repeat (15) hit(3);
      chk({4'h0, stack_ptr}, 8'h0f);
      hit(3);
      hit(4);
      chk(processor_status, 8'h1c);
      rst(1'b0);
      chk({stack_ptr, processor_status[5:2]}, 8'h0f);
      wr(8'h04, 8'h00);
      hit(5);
      wr(8'h04, 8'h50);
      hit(6);
      wr(8'h04, 8'ha0);
      hit(5);
      chk(p0, 8'hff);
      chk(p1, 8'h01);
      // Flag logic wins over a same-cycle write of the flags
      @(posedge mclk) {wr_en, wr_addr, wr_data, alu_op, alu_a, alu_b} <=
         {1'b1, 8'h04, 8'h0f, 3'h1, 8'h01, 8'h01};
      @(posedge mclk) {wr_en, alu_op} <= 4'h0;
      #1 chk(arith_status, 8'h00);
      @(posedge mclk) rd_addr <= 8'h06;
      @(posedge mclk) #1 chk(rd_data, 8'h3c);
      end_of_test;
   end
endmodule
bind cas_status_regs cas_status_sva i_sva (.mclk, .rst_b, .alu_op, .alu_a, .alu_b,
   .alu_result, .wr_en, .wr_addr, .wr_data, .sleep_instr, .irq_pending, .irq_enable,
   .irq_take, .stack_ptr, .arith_status, .processor_status);
